// *** rtl/gbrc_reset_ctrl.sv ***
`timescale 1ns/1ns
`include "gbrc_params.svh"

// What this block does
// (RULE1) global reset: outputs released, all registers reset
// (RULE2) global reset leaves complete default state
// (RULE3) system uses global reset only at boot
// (RULE4) later the host bus reset is used instead
// (RULE5) without wake need, tie both resets together
// (RULE6) suspend keeps registers under global reset
// (RULE7) bus reset: outputs released, subset cleared
// (RULE8) no function during bus reset, default after
// (RULE9) suspend plus bus reset keeps all registers
// (RULE10) everything sampled on rising bus clock edge
// (RULE11) wake context cleared only by global reset
module gbrc_reset_ctrl
  import gbrc_pkg::*;
#(
  parameter int DATA_W = 8
) (
  input  wire logic              clk_sys_in,
  input  wire logic              arst_n_in,
  input  wire gbrc_rst_req_t     rst_req_in,
  input  wire gbrc_wr_req_t      wr_req_in,
  input  wire logic              drive_req_in,
  input  wire logic [DATA_W-1:0] drive_data_in,
  output logic                   drive_oe_out,
  output logic      [DATA_W-1:0] drive_data_out,
  output logic      [DATA_W-1:0] wake_ctx_out,
  output logic      [DATA_W-1:0] config_out,
  output logic                   active_out
);

  gbrc_main_state_t st;
  gbrc_main_state_t next_st;

  logic any_rst;
  logic clear_wake;
  logic clear_cfg;
  logic load_wake;
  logic load_cfg;
  logic write_ok;

  // reset qualification, sampled on the rising bus clock edge [RULE10]
  assign any_rst    = rst_req_in.global_reset | rst_req_in.host_bus_reset;
  // wake context clears on global reset only, not under suspend [RULE11] [RULE6] [RULE2]
  assign clear_wake = rst_req_in.global_reset & ~rst_req_in.suspend;
  // ordinary registers clear on either reset unless suspended [RULE7] [RULE9] [RULE1]
  assign clear_cfg  = any_rst & ~rst_req_in.suspend;
  // no writes taken while any reset is active [RULE8]
  assign write_ok   = wr_req_in.valid & ~any_rst;
  assign load_wake  = write_ok & (wr_req_in.sel == `GBRC_SEL_WAKE);
  assign load_cfg   = write_ok & (wr_req_in.sel == `GBRC_SEL_CFG);

  // wake context register, global reset domain
  gbrc_keep_reg #(
    .WIDTH   (DATA_W),
    .RST_VAL (`GBRC_WAKE_RST_VAL)
  ) u_wake (
    .clk_sys_in (clk_sys_in),
    .arst_n_in  (arst_n_in),
    .clear_in   (clear_wake),
    .load_in    (load_wake),
    .data_in    (wr_req_in.data[DATA_W-1:0]),
    .value_out  (wake_ctx_out)
  );

  // configuration register, bus reset domain
  gbrc_keep_reg #(
    .WIDTH   (DATA_W),
    .RST_VAL (`GBRC_CFG_RST_VAL)
  ) u_cfg (
    .clk_sys_in (clk_sys_in),
    .arst_n_in  (arst_n_in),
    .clear_in   (clear_cfg),
    .load_in    (load_cfg),
    .data_in    (wr_req_in.data[DATA_W-1:0]),
    .value_out  (config_out)
  );

  // next state: outputs released during any reset, data kept under suspend
  always_comb begin
    next_st = st;
    case (st.state)
      GBRC_ST_ACTIVE, GBRC_ST_RESET, GBRC_ST_HOLD: begin
        if (!any_rst) begin
          next_st.state = GBRC_ST_ACTIVE;
        end else if (rst_req_in.suspend) begin
          next_st.state = GBRC_ST_HOLD;
        end else begin
          next_st.state = GBRC_ST_RESET;
        end
      end
      default: begin
        next_st.state = GBRC_ST_RESET;
      end
    endcase
    // outputs are registered, so they go quiet one edge after a reset
    // is sampled and come back one edge after its release
    next_st.active   = ~any_rst;                 // [RULE8]
    next_st.drive_oe = ~any_rst & drive_req_in;  // [RULE1] [RULE7]
    if (clear_cfg) begin
      next_st.drive_data = DATA_W'(`GBRC_DRIVE_RST_VAL);  // [RULE2]
    end else if (!any_rst && drive_req_in) begin
      next_st.drive_data = drive_data_in;
    end
  end

  // state register
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= '{state: GBRC_ST_RESET, active: 1'b0, drive_oe: 1'b0, drive_data: '0};
    end else begin
      st <= next_st;
    end
  end

  assign drive_oe_out   = st.drive_oe;
  assign drive_data_out = st.drive_data;
  assign active_out     = st.active;

  // checks on reset behaviour
  a_rst_outputs_off: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RULE1]
    any_rst |=> !drive_oe_out)
    else $error("output enabled after a reset cycle");

  a_global_full_clear: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RULE2]
    (rst_req_in.global_reset && !rst_req_in.suspend) |=>
      (wake_ctx_out == DATA_W'(`GBRC_WAKE_RST_VAL)) &&
      (config_out == DATA_W'(`GBRC_CFG_RST_VAL)) &&
      (drive_data_out == DATA_W'(`GBRC_DRIVE_RST_VAL)))
    else $error("global reset left state behind");

  a_suspend_keeps_all: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RULE6]
    (rst_req_in.global_reset && rst_req_in.suspend) |=>
      $stable(wake_ctx_out) && $stable(config_out) && !drive_oe_out)
    else $error("suspend did not protect registers from global reset");

  a_bus_rst_clears: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RULE7]
    (rst_req_in.host_bus_reset && !rst_req_in.suspend) |=>
      (config_out == DATA_W'(`GBRC_CFG_RST_VAL)) && !drive_oe_out)
    else $error("bus reset did not clear its registers");

  a_bus_rst_default: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RULE8]
    (rst_req_in.host_bus_reset && !rst_req_in.suspend) ##1
      (!any_rst && !wr_req_in.valid) |->
      !active_out ##1 (active_out && config_out == DATA_W'(`GBRC_CFG_RST_VAL)))
    else $error("not in default state after bus reset release");

  a_bus_susp_keep: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RULE9]
    (rst_req_in.host_bus_reset && rst_req_in.suspend) |=>
      $stable(config_out) && $stable(drive_data_out) && !drive_oe_out && !active_out)
    else $error("suspend did not protect registers from bus reset");

  a_wake_survives_bus: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RULE11]
    (rst_req_in.host_bus_reset && !rst_req_in.global_reset) |=> $stable(wake_ctx_out))
    else $error("wake context lost on bus reset");

  a_write_on_edge: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RULE10]
    (wr_req_in.valid && !any_rst && wr_req_in.sel == `GBRC_SEL_CFG) |=>
      config_out == $past(wr_req_in.data[DATA_W-1:0]))
    else $error("write not taken on the sampling edge");

  a_wake_write_edge: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RULE10]
    (wr_req_in.valid && !any_rst && wr_req_in.sel == `GBRC_SEL_WAKE) |=>
      wake_ctx_out == $past(wr_req_in.data[DATA_W-1:0]))
    else $error("wake context write not taken on the sampling edge");

  a_drive_capture: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RULE10]
    (drive_req_in && !any_rst) |=>
      drive_oe_out && (drive_data_out == $past(drive_data_in)))
    else $error("drive request not taken on the sampling edge");

  a_oe_needs_request: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RULE10]
    !drive_req_in |=>
      !drive_oe_out)
    else $error("output enabled without a drive request");

  // registers hold unless cleared or written
  a_cfg_kept: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RULE9]
    (!clear_cfg && !load_cfg) |=>
      $stable(config_out))
    else $error("config register changed without write or clear");

  a_wake_kept: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RULE11]
    (!clear_wake && !load_wake) |=>
      $stable(wake_ctx_out))
    else $error("wake context changed without write or global reset");

  a_drive_data_kept: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RULE9]
    (!clear_cfg && !(drive_req_in && !any_rst)) |=>
      $stable(drive_data_out))
    else $error("drive data changed without capture or clear");

  a_susp_no_clear: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RULE6]
    (any_rst && rst_req_in.suspend) |=>
      $stable(drive_data_out) && $stable(config_out))
    else $error("suspend did not protect the drive data");

  // function stops for exactly the reset cycles
  a_rst_stops_function: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RULE8]
    any_rst |=>
      !active_out && !drive_oe_out)
    else $error("block still functional after a reset cycle");

  a_susp_alone_runs: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RULE8]
    !any_rst |=>
      active_out)
    else $error("block not functional without a reset");

  // state encoding is one-hot and agrees with the registered outputs
  a_state_onehot: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RULE2]
    $onehot(st.state))
    else $error("state code not one-hot");

  a_active_state_on: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RULE8]
    (st.state == GBRC_ST_ACTIVE) |->
      active_out)
    else $error("active state without active output");

  a_reset_state_quiet: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RULE7]
    (st.state == GBRC_ST_RESET) |->
      !active_out && !drive_oe_out)
    else $error("reset state with outputs enabled");

  a_hold_state_quiet: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in) // [RULE9]
    (st.state == GBRC_ST_HOLD) |->
      !active_out && !drive_oe_out)
    else $error("hold state with outputs enabled");

endmodule

// *** rtl/gbrc_params.svh ***
`ifndef GBRC_PARAMS_SVH
`define GBRC_PARAMS_SVH

// reset values of the retained registers
`define GBRC_WAKE_RST_VAL  8'h00
`define GBRC_CFG_RST_VAL   8'h00
`define GBRC_DRIVE_RST_VAL 8'h00

// write select codes
`define GBRC_SEL_WAKE      1'h0
`define GBRC_SEL_CFG       1'h1

`endif

// *** rtl/gbrc_pkg.sv ***
package gbrc_pkg;

  // block state, one-hot
  typedef enum logic [2:0] {
    GBRC_ST_ACTIVE = 3'h1,
    GBRC_ST_RESET  = 3'h2,
    GBRC_ST_HOLD   = 3'h4
  } gbrc_state_t;

  // user-side write request
  typedef struct packed {
    logic       valid;
    logic       sel;
    logic [7:0] data;
  } gbrc_wr_req_t;

  // reset inputs as one group
  typedef struct packed {
    logic global_reset;
    logic host_bus_reset;
    logic suspend;
  } gbrc_rst_req_t;

  // main module state
  typedef struct packed {
    gbrc_state_t state;
    logic        active;
    logic        drive_oe;
    logic [7:0]  drive_data;
  } gbrc_main_state_t;

endpackage

// *** rtl/gbrc_keep_reg.sv ***
`timescale 1ns/1ns
`include "gbrc_params.svh"

// register that returns to its reset value on clear, else loads on load
module gbrc_keep_reg
  import gbrc_pkg::*;
#(
  parameter int         WIDTH   = 8,
  parameter logic [7:0] RST_VAL = 8'h00
) (
  input  wire logic             clk_sys_in,
  input  wire logic             arst_n_in,
  input  wire logic             clear_in,
  input  wire logic             load_in,
  input  wire logic [WIDTH-1:0] data_in,
  output logic      [WIDTH-1:0] value_out
);

  typedef struct packed {
    logic [WIDTH-1:0] value;
  } gbrc_keep_state_t;

  gbrc_keep_state_t st;
  gbrc_keep_state_t next_st;

  // clear has priority over load
  always_comb begin
    next_st = st;
    if (clear_in) begin
      next_st.value = WIDTH'(RST_VAL);
    end else if (load_in) begin
      next_st.value = data_in;
    end
  end

  // state register
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign value_out = st.value;

endmodule

// *** sim/gbrc_sys_model.sv ***
`timescale 1ns/1ns

// system reset source: global reset at boot, bus reset later, optional tie
module gbrc_sys_model
  import gbrc_pkg::*;
(
  input  wire logic    clk_sys_in,
  input  wire logic    boot_in,
  input  wire logic    bus_rst_in,
  input  wire logic    tie_in,
  input  wire logic    susp_in,
  output gbrc_rst_req_t rst_req_out
);
  // levels are taken from the bench at the rising edge and applied by
  // non-blocking assignment, so the design samples them at the next edge
  always @(posedge clk_sys_in) begin
    rst_req_out.global_reset   <= boot_in | (tie_in & bus_rst_in);
    rst_req_out.host_bus_reset <= bus_rst_in;
    rst_req_out.suspend        <= susp_in;
  end
endmodule

// *** sim/gbrc_reset_ctrl_test.sv ***
`timescale 1ns/1ns
`include "gbrc_params.svh"

// random stimulus checked against a cycle model of the reset controller
module gbrc_reset_ctrl_test
  import gbrc_pkg::*;
;
  logic          clk_sys_in = 1'b1;
  logic          arst_n_in  = 1'b0;
  logic          boot       = 1'b1;
  logic          bus_rst    = 1'b0;
  logic          tie        = 1'b0;
  logic          susp       = 1'b0;
  logic          drive_req  = 1'b0;
  logic [7:0]    drive_data = 8'h00;
  gbrc_wr_req_t  wr         = '0;
  gbrc_rst_req_t rq;
  logic          oe;
  logic          act;
  logic [7:0]    dout;
  logic [7:0]    wake;
  logic [7:0]    cfg;
  logic [7:0]    m_wake;
  logic [7:0]    m_cfg;
  logic [7:0]    m_dd;
  logic          m_oe;
  logic          m_act;
  logic [31:0]   seed       = 32'h0000_0048;
  int            n_errors   = 0;
  int            num_checks = 0;

  always #25 clk_sys_in = ~clk_sys_in;

  gbrc_sys_model SYS (.clk_sys_in(clk_sys_in), .boot_in(boot), .bus_rst_in(bus_rst),
    .tie_in(tie), .susp_in(susp), .rst_req_out(rq));

  gbrc_reset_ctrl DUT (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .rst_req_in(rq),
    .wr_req_in(wr), .drive_req_in(drive_req), .drive_data_in(drive_data),
    .drive_oe_out(oe), .drive_data_out(dout), .wake_ctx_out(wake), .config_out(cfg),
    .active_out(act));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  task automatic chk_w(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_f(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    if (n_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // reference model, same edges as the design
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      m_wake = `GBRC_WAKE_RST_VAL;
      m_cfg  = `GBRC_CFG_RST_VAL;
      m_dd   = `GBRC_DRIVE_RST_VAL;
      m_oe   = 1'b0;
      m_act  = 1'b0;
    end else begin
      if ((rq.global_reset | rq.host_bus_reset) & ~rq.suspend) begin
        m_cfg = `GBRC_CFG_RST_VAL;
        m_dd  = `GBRC_DRIVE_RST_VAL;
        if (rq.global_reset) m_wake = `GBRC_WAKE_RST_VAL;
      end else if (!(rq.global_reset | rq.host_bus_reset)) begin
        if (wr.valid && wr.sel == `GBRC_SEL_CFG) m_cfg = wr.data;
        if (wr.valid && wr.sel == `GBRC_SEL_WAKE) m_wake = wr.data;
        if (drive_req) m_dd = drive_data;
      end
      m_oe  = drive_req & ~(rq.global_reset | rq.host_bus_reset);
      m_act = ~(rq.global_reset | rq.host_bus_reset);
    end
  end

  // boot phase, bus reset phase, then tied resets; fixed-length run
  initial begin
    repeat (6) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    arst_n_in = 1'b1;
    for (int i = 0; i < 2000; i++) begin
      @(negedge clk_sys_in);
      chk_w(wake, m_wake);
      chk_w(cfg, m_cfg);
      chk_w(dout, m_dd);
      chk_f(oe, m_oe);
      chk_f(act, m_act);
      seed       = xs(seed);
      boot       = (i < 8);
      tie        = (i >= 1000);
      bus_rst    = (seed[18:16] == 3'h0);
      susp       = (seed[21:20] == 2'h0);
      drive_req  = seed[2];
      drive_data = seed[31:24];
      wr         = '{valid: seed[0], sel: seed[1], data: seed[15:8]};
    end
    end_sim;
  end
endmodule
